// file: rtl/gpr_pkg.sv
// Purpose: shared constants for the gpio port register bank
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   offsets are byte offsets from either alias base
package gpr_pkg;

	localparam int          PIN_COUNT        = 32;
	localparam int          DATA_W           = 32;
	localparam int          ADDR_W           = 32;
	localparam int          IDX_W            = 5;

	// Alias bases and the size of the decoded window
	localparam logic [31:0] BASE_SECURE      = 32'h5084_2500;
	localparam logic [31:0] BASE_NONSECURE   = 32'h4084_2500;
	localparam logic [11:0] WINDOW_SPAN      = 12'h300;

	// Register offsets
	localparam logic [11:0] OFS_DRIVE_LEVEL  = 12'h004;
	localparam logic [11:0] OFS_DRIVE_SET    = 12'h008;
	localparam logic [11:0] OFS_DRIVE_CLEAR  = 12'h00C;
	localparam logic [11:0] OFS_INPUT_LEVEL  = 12'h010;
	localparam logic [11:0] OFS_DIRECTION    = 12'h014;
	localparam logic [11:0] OFS_DIR_SET      = 12'h018;
	localparam logic [11:0] OFS_DIR_CLEAR    = 12'h01C;
	localparam logic [11:0] OFS_SENSE_HIT    = 12'h020;
	localparam logic [11:0] OFS_NS_DET_SEL   = 12'h024;
	localparam logic [11:0] OFS_SEC_DET_SEL  = 12'h028;
	localparam logic [11:0] OFS_IRQ_STATUS   = 12'h100;
	localparam logic [11:0] OFS_IRQ_ENABLE   = 12'h104;
	localparam logic [11:0] OFS_IRQ_CLEAR    = 12'h108;
	localparam logic [11:0] OFS_PIN_CFG_LO   = 12'h200;
	localparam logic [11:0] OFS_PIN_CFG_HI   = 12'h27C;

	// Reset values
	localparam logic [31:0] RST_DRIVE_LEVEL  = 32'h0000_0000;
	localparam logic [31:0] RST_DIRECTION    = 32'h0000_0000;
	localparam logic [31:0] RST_SENSE_HIT    = 32'h0000_0000;
	localparam logic [31:0] RST_PIN_CFG      = 32'h0000_0000;
	localparam logic        RST_DET_SEL      = 1'b0;
	localparam logic [1:0]  RST_IRQ          = 2'h0;

	// Fields
	localparam int          DET_SEL_BIT      = 0;
	localparam int          SENSE_LSB        = 16;
	localparam logic [1:0]  SENSE_OFF        = 2'h0;
	localparam logic [1:0]  SENSE_HIGH       = 2'h2;
	localparam logic [1:0]  SENSE_LOW        = 2'h3;
	localparam int          IRQ_NS_DETECT    = 0;
	localparam int          IRQ_SEC_DETECT   = 1;
	localparam int          IRQ_W            = 2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_DONE
	} gpr_bus_state_t;

endpackage : gpr_pkg

// file: rtl/gpr_cfg_if.sv
// Purpose: carrier between the register bank and its pin config store
// Assumes: single clock, write and read in the same cycle allowed
// Notes:   bit mask selects which written bits take effect
`timescale 1ns/1ps
interface gpr_cfg_if;
	logic        wr_en;
	logic [4:0]  wr_idx;
	logic [31:0] wr_data;
	logic [31:0] wr_bits;
	logic [4:0]  rd_idx;
	logic [31:0] rd_data;

	modport bank
	(
		output wr_en,
		output wr_idx,
		output wr_data,
		output wr_bits,
		output rd_idx,
		input  rd_data
	);

	modport store
	(
		input  wr_en,
		input  wr_idx,
		input  wr_data,
		input  wr_bits,
		input  rd_idx,
		output rd_data
	);
endinterface : gpr_cfg_if

// file: rtl/gpr_cfg_mem.sv
// Purpose: per-pin configuration word store, registered read port
// Assumes: one write port with bit mask, one read port
// Notes:   read data lags the read index by one clock
`timescale 1ns/1ps
module gpr_cfg_mem
	import gpr_pkg::*;
#(
	parameter int DEPTH = PIN_COUNT
)
(
	input  wire logic clk_in,
	input  wire logic rst_in,
	gpr_cfg_if.store  cfg
);

	logic [31:0] mem_r [DEPTH];
	logic [31:0] rd_r;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= RST_PIN_CFG;
		end
		else if (cfg.wr_en)
		begin
			mem_r[cfg.wr_idx] <= (mem_r[cfg.wr_idx] & ~cfg.wr_bits) |
				(cfg.wr_data & cfg.wr_bits);
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			rd_r <= RST_PIN_CFG;
		else
			rd_r <= mem_r[cfg.rd_idx];
	end

	assign cfg.rd_data = rd_r;

endmodule : gpr_cfg_mem

// file: rtl/gpr_port.sv
// Purpose: register bank of a 32-pin general purpose port on APB
// Assumes: secure pin mask comes from logic on the same clock
// Notes:   pin inputs pass a two-flop synchroniser before use
//
// Notes on behaviour
// - The bank is decoded at a secure alias base and at a non-secure alias base.
// - The drive-level register holds one bit per pin, 1 drives high, and resets to zero.
// - Writing 1s to the drive set register sets those drive-level bits, 0s change nothing.
// - Writing 1s to the drive clear register clears those drive-level bits, 0s change nothing.
// - Reading the drive set or clear register returns the drive-level register.
// - A direction register has its own set and clear registers beside it.
// - A sense-hit register records which pins have met their sense criterion.
// - A select register picks direct or latched detect output for non-secure pins.
// - A second select register makes the same choice for secure pins.
// - Per-pin configuration words start at 0x200 and the input level sits at 0x010.
// - Non-secure accesses to secure pins or their registers write nothing and read zero; the irq status, enable and clear registers are open to both.
// - A sense-hit bit clears only on a written 1 and not while its detect is high.
`timescale 1ns/1ps
module gpr_port
	import gpr_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [ADDR_W-1:0] paddr_in,
	input  wire logic [DATA_W-1:0] pwdata_in,
	input  wire logic [3:0]        pstrb_in,
	input  wire logic [2:0]        pprot_in,
	output logic                   pready_out,
	output logic      [DATA_W-1:0] prdata_out,
	output logic                   pslverr_out,
	input  wire logic [31:0]       pin_secure_in,
	input  wire logic [31:0]       pin_level_in,
	output logic      [31:0]       pin_drive_out,
	output logic      [31:0]       pin_drive_en_n_out,
	output logic                   detect_nsec_out,
	output logic                   detect_sec_out,
	output logic                   irq_out
);

	////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [31:0] lane_bits(input logic [3:0] strb);
		return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction : lane_bits

	function automatic logic in_alias(input logic [31:0] a, input logic [31:0] base);
		logic [31:0] d;
		d = a - base;
		return (a >= base) && (d < {20'h0_0000, WINDOW_SPAN});
	endfunction : in_alias

	////////////////////////////////////////////////////////////////////
	// State

	gpr_bus_state_t state_r;
	logic [31:0]    drive_r;
	logic [31:0]    dir_r;
	logic [31:0]    hit_r;
	logic [31:0]    hit_nxt;
	logic           ns_sel_r;
	logic           sec_sel_r;
	logic [1:0]     sense_r [PIN_COUNT];
	logic [31:0]    sync1_r;
	logic [31:0]    sync2_r;
	logic [31:0]    detect_r;
	logic [31:0]    detect_d_r;
	logic           gap_r;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_en_r;
	logic           det_ns_d_r;
	logic           det_sec_d_r;
	logic [31:0]    rdata_r;

	gpr_cfg_if cfg();

	gpr_cfg_mem #(
		.DEPTH (PIN_COUNT)
	) u_cfg (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.cfg    (cfg)
	);

	////////////////////////////////////////////////////////////////////
	// Decode

	logic        hit_s;
	logic        hit_ns;
	logic        ns_acc;
	logic [11:0] ofs;
	logic [31:0] pin_ok;
	logic [31:0] wbits;
	logic        wr_go;
	logic        is_cfg;
	logic [4:0]  cfg_idx;

	assign hit_s   = in_alias(paddr_in, BASE_SECURE);
	assign hit_ns  = in_alias(paddr_in, BASE_NONSECURE);
	assign ns_acc  = hit_ns | pprot_in[1];
	assign ofs     = hit_s ? 12'(paddr_in - BASE_SECURE) : 12'(paddr_in - BASE_NONSECURE);
	// Non-secure sees only non-secure pins
	assign pin_ok  = ns_acc ? ~pin_secure_in : 32'hFFFF_FFFF;
	assign wbits   = lane_bits(pstrb_in) & pin_ok;
	assign wr_go   = psel_in & penable_in & pwrite_in & (state_r == ST_DONE) &
		(hit_s | hit_ns) & (ofs[1:0] == 2'h0);
	assign is_cfg  = (ofs >= OFS_PIN_CFG_LO) && (ofs <= OFS_PIN_CFG_HI);
	assign cfg_idx = ofs[6:2];

	logic wr_drive;
	logic wr_dset;
	logic wr_dclr;
	logic wr_dir;
	logic wr_direction_set_reg;
	logic wr_direction_clear_reg;
	logic wr_hit;
	logic wr_nssel;
	logic wr_secsel;
	logic wr_irqen;
	logic wr_irqclr;
	logic cfg_allowed;

	always_comb
	begin
		wr_drive  = 1'b0;
		wr_dset   = 1'b0;
		wr_dclr   = 1'b0;
		wr_dir    = 1'b0;
		wr_direction_set_reg = 1'b0;
		wr_direction_clear_reg = 1'b0;
		wr_hit    = 1'b0;
		wr_nssel  = 1'b0;
		wr_secsel = 1'b0;
		wr_irqen  = 1'b0;
		wr_irqclr = 1'b0;
		if (!wr_go)
			wr_drive = 1'b0;
		else if (ofs == OFS_DRIVE_LEVEL)
			wr_drive = 1'b1;
		else if (ofs == OFS_DRIVE_SET)
			wr_dset = 1'b1;
		else if (ofs == OFS_DRIVE_CLEAR)
			wr_dclr = 1'b1;
		else if (ofs == OFS_DIRECTION)
			wr_dir = 1'b1;
		else if (ofs == OFS_DIR_SET)
			wr_direction_set_reg = 1'b1;
		else if (ofs == OFS_DIR_CLEAR)
			wr_direction_clear_reg = 1'b1;
		else if (ofs == OFS_SENSE_HIT)
			wr_hit = 1'b1;
		else if (ofs == OFS_NS_DET_SEL)
			wr_nssel = 1'b1;
		else if (ofs == OFS_SEC_DET_SEL)
			wr_secsel = !ns_acc;
		else if (ofs == OFS_IRQ_ENABLE)
			wr_irqen = 1'b1;
		else if (ofs == OFS_IRQ_CLEAR)
			wr_irqclr = 1'b1;
	end

	// Secure pin words are closed to non-secure masters
	assign cfg_allowed = is_cfg && !(ns_acc && pin_secure_in[cfg_idx]);
	assign cfg.wr_en   = wr_go & cfg_allowed;
	assign cfg.wr_idx  = cfg_idx;
	assign cfg.wr_data = pwdata_in;
	assign cfg.wr_bits = lane_bits(pstrb_in);
	assign cfg.rd_idx  = cfg_idx;

	////////////////////////////////////////////////////////////////////
	// Drive and direction

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			drive_r <= RST_DRIVE_LEVEL;
		else if (wr_drive)
			drive_r <= (drive_r & ~wbits) | (pwdata_in & wbits);
		else if (wr_dset)
			drive_r <= drive_r | (pwdata_in & wbits);
		else if (wr_dclr)
			drive_r <= drive_r & ~(pwdata_in & wbits);
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			dir_r <= RST_DIRECTION;
		else if (wr_dir)
			dir_r <= (dir_r & ~wbits) | (pwdata_in & wbits);
		else if (wr_direction_set_reg)
			dir_r <= dir_r | (pwdata_in & wbits);
		else if (wr_direction_clear_reg)
			dir_r <= dir_r & ~(pwdata_in & wbits);
	end

	assign pin_drive_out      = drive_r;
	assign pin_drive_en_n_out = ~dir_r;

	////////////////////////////////////////////////////////////////////
	// Sense and detect

	// Shadow of the sense fields so all pins compare at once
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < PIN_COUNT; i++)
				sense_r[i] <= RST_PIN_CFG[SENSE_LSB +: 2];
		end
		else if (cfg.wr_en)
		begin
			for (int b = 0; b < 2; b++)
				if (cfg.wr_bits[SENSE_LSB + b])
					sense_r[cfg_idx][b] <= pwdata_in[SENSE_LSB + b];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sync1_r <= 32'h0000_0000;
			sync2_r <= 32'h0000_0000;
		end
		else
		begin
			sync1_r <= pin_level_in;
			sync2_r <= sync1_r;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			detect_r   <= 32'h0000_0000;
			detect_d_r <= 32'h0000_0000;
		end
		else
		begin
			for (int i = 0; i < PIN_COUNT; i++)
				detect_r[i] <= ((sense_r[i] == SENSE_HIGH) && sync2_r[i]) ||
					((sense_r[i] == SENSE_LOW) && !sync2_r[i]);
			detect_d_r <= detect_r;
		end
	end

	// Set wins; a clear is refused while detect is high
	always_comb
	begin
		hit_nxt = hit_r;
		if (wr_hit)
			hit_nxt = hit_nxt & ~(pwdata_in & wbits & ~detect_r);
		hit_nxt = hit_nxt | (detect_r & ~detect_d_r);
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			hit_r <= RST_SENSE_HIT;
		else
			hit_r <= hit_nxt;
	end

	// One low cycle after a clear so leftover flags make a fresh edge
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			gap_r <= 1'b0;
		else
			gap_r <= wr_hit;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ns_sel_r  <= RST_DET_SEL;
			sec_sel_r <= RST_DET_SEL;
		end
		else
		begin
			if (wr_nssel && wbits[DET_SEL_BIT])
				ns_sel_r <= pwdata_in[DET_SEL_BIT];
			if (wr_secsel && wbits[DET_SEL_BIT])
				sec_sel_r <= pwdata_in[DET_SEL_BIT];
		end
	end

	logic lat_ns;
	logic lat_sec;

	assign lat_ns  = |(hit_r & ~pin_secure_in) & ~gap_r;
	assign lat_sec = |(hit_r & pin_secure_in) & ~gap_r;
	assign detect_nsec_out = ns_sel_r ? lat_ns : |(detect_r & ~pin_secure_in);
	assign detect_sec_out  = sec_sel_r ? lat_sec : |(detect_r & pin_secure_in);

	////////////////////////////////////////////////////////////////////
	// Interrupts

	logic [IRQ_W-1:0] irq_set;

	assign irq_set[IRQ_NS_DETECT]  = detect_nsec_out & ~det_ns_d_r;
	assign irq_set[IRQ_SEC_DETECT] = detect_sec_out & ~det_sec_d_r;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			det_ns_d_r  <= 1'b0;
			det_sec_d_r <= 1'b0;
			irq_stat_r  <= RST_IRQ;
			irq_en_r    <= RST_IRQ;
		end
		else
		begin
			det_ns_d_r  <= detect_nsec_out;
			det_sec_d_r <= detect_sec_out;
			// Set beats a clear in the same cycle
			irq_stat_r  <= (irq_stat_r &
				~(wr_irqclr ? pwdata_in[IRQ_W-1:0] : RST_IRQ)) | irq_set;
			if (wr_irqen)
				irq_en_r <= pwdata_in[IRQ_W-1:0];
		end
	end

	assign irq_out = |(irq_stat_r & irq_en_r);

	////////////////////////////////////////////////////////////////////
	// APB answer: one fetch cycle so config reads come from the store

	logic [31:0] rd_mux;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (!(hit_s | hit_ns) || (ofs[1:0] != 2'h0))
			rd_mux = 32'h0000_0000;
		else if (ofs == OFS_DRIVE_LEVEL || ofs == OFS_DRIVE_SET || ofs == OFS_DRIVE_CLEAR)
			rd_mux = drive_r & pin_ok;
		else if (ofs == OFS_INPUT_LEVEL)
			rd_mux = sync2_r & pin_ok;
		else if (ofs == OFS_DIRECTION || ofs == OFS_DIR_SET || ofs == OFS_DIR_CLEAR)
			rd_mux = dir_r & pin_ok;
		else if (ofs == OFS_SENSE_HIT)
			rd_mux = hit_r & pin_ok;
		else if (ofs == OFS_NS_DET_SEL)
			rd_mux = {31'h0000_0000, ns_sel_r};
		else if (ofs == OFS_SEC_DET_SEL)
			rd_mux = {31'h0000_0000, sec_sel_r & ~ns_acc};
		else if (ofs == OFS_IRQ_STATUS)
			rd_mux = {30'h0000_0000, irq_stat_r};
		else if (ofs == OFS_IRQ_ENABLE)
			rd_mux = {30'h0000_0000, irq_en_r};
		else if (cfg_allowed)
			rd_mux = cfg.rd_data;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			state_r <= ST_IDLE;
		else
		begin
			case (state_r)
				ST_IDLE:
					if (psel_in)
						state_r <= ST_FETCH;
				ST_FETCH:
					if (psel_in && penable_in)
						state_r <= ST_DONE;
				ST_DONE:
					state_r <= ST_IDLE;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			rdata_r <= 32'h0000_0000;
		else if (state_r == ST_FETCH && psel_in && penable_in && !pwrite_in)
			rdata_r <= rd_mux;
	end

	assign pready_out  = (state_r == ST_DONE);
	assign prdata_out  = rdata_r;
	assign pslverr_out = 1'b0;

endmodule : gpr_port

// file: sim/gpr_port_properties.sv
// Purpose: concurrent checks on the port register bank pins
// Assumes: data checks use secure alias accesses with full strobes
// Notes:   bound to every gpr_port instance
`timescale 1ns/1ps
module gpr_port_properties
	import gpr_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [ADDR_W-1:0] paddr_in,
	input  wire logic [DATA_W-1:0] pwdata_in,
	input  wire logic [3:0]        pstrb_in,
	input  wire logic [2:0]        pprot_in,
	input  wire logic              pready_out,
	input  wire logic [DATA_W-1:0] prdata_out,
	input  wire logic              pslverr_out,
	input  wire logic [31:0]       pin_drive_out,
	input  wire logic [31:0]       pin_drive_en_n_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	logic [31:0] ofs;
	logic        done;
	logic        sec_done;
	assign ofs      = paddr_in - BASE_SECURE;
	assign done     = psel_in && penable_in && pready_out;
	// Only full-word secure accesses, so strobes and masks drop out
	assign sec_done = done && !pprot_in[1] && pstrb_in == 4'hF && ofs < 32'h0000_0300;

	sequence s_setup;
		psel_in && !penable_in;
	endsequence
	sequence s_wait;
		!pready_out ##1 pready_out;
	endsequence

	////////////////////////////////////////////////////////////////
	a_ready_wait_state: assert property (s_setup |=> s_wait)
		else $error("ready not in second access cycle");
	a_ready_one_cycle: assert property (pready_out |=> !pready_out)
		else $error("ready held too long");
	a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
		else $error("ready outside access phase");
	a_no_slave_err: assert property (!pslverr_out)
		else $error("slave error raised");
	a_drive_write: assert property (sec_done && pwrite_in && ofs[11:0] == OFS_DRIVE_LEVEL
		|=> pin_drive_out == $past(pwdata_in))
		else $error("drive level write lost");
	a_drive_set: assert property (sec_done && pwrite_in && ofs[11:0] == OFS_DRIVE_SET
		|=> pin_drive_out == ($past(pin_drive_out) | $past(pwdata_in)))
		else $error("drive set wrong");
	a_drive_clear: assert property (sec_done && pwrite_in && ofs[11:0] == OFS_DRIVE_CLEAR
		|=> pin_drive_out == ($past(pin_drive_out) & ~$past(pwdata_in)))
		else $error("drive clear wrong");
	a_drive_hold: assert property (!(done && pwrite_in) |=> $stable(pin_drive_out))
		else $error("drive changed without write");
	a_dir_hold: assert property (!(done && pwrite_in) |=> $stable(pin_drive_en_n_out))
		else $error("direction changed without write");
	a_mirror_read: assert property (sec_done && !pwrite_in
		&& (ofs[11:0] == OFS_DRIVE_SET || ofs[11:0] == OFS_DRIVE_CLEAR)
		|-> prdata_out == pin_drive_out)
		else $error("set or clear read not mirrored");
	a_unmapped_zero: assert property (sec_done && !pwrite_in && ofs[11:0] == 12'h030
		|-> prdata_out == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule : gpr_port_properties

bind gpr_port gpr_port_properties gpr_port_properties_i
(
	.clk_in             (clk_in),
	.rst_in             (rst_in),
	.psel_in            (psel_in),
	.penable_in         (penable_in),
	.pwrite_in          (pwrite_in),
	.paddr_in           (paddr_in),
	.pwdata_in          (pwdata_in),
	.pstrb_in           (pstrb_in),
	.pprot_in           (pprot_in),
	.pready_out         (pready_out),
	.prdata_out         (prdata_out),
	.pslverr_out        (pslverr_out),
	.pin_drive_out      (pin_drive_out),
	.pin_drive_en_n_out (pin_drive_en_n_out)
);

// file: sim/testbench.sv
// Purpose: self-checking bench for the port register bank
// Assumes: pins 0..7 secure, row op bit1 write, bit0 non-secure
// Notes:   bus answers are taken at rising edges, pins at falling ones except the first reset checks
`timescale 1ns/1ps
module testbench
	import gpr_pkg::*;
;
	typedef struct packed {
		logic [1:0]  op;
		logic [11:0] ofs;
		logic [31:0] val;
		logic [31:0] drv;
	} gpr_tb_row_t;

	logic        clk_in, rst_in, psel_in, penable_in, pwrite_in;
	logic [31:0] paddr_in, pwdata_in, pin_secure_in, pin_level_in, rd;
	logic [3:0]  pstrb_in;
	logic [2:0]  pprot_in;
	logic        pready_out, pslverr_out, detect_nsec_out, detect_sec_out, irq_out;
	logic [31:0] prdata_out, pin_drive_out, pin_drive_en_n_out;
	int          fail_count = 0;
	int          check_count = 0;

	gpr_tb_row_t rows [0:30] = '{
		'{2'h2, 12'h004, 32'hA5A5_0F0F, 32'hA5A5_0F0F},
		'{2'h0, 12'h008, 32'hA5A5_0F0F, 32'hA5A5_0F0F},
		'{2'h2, 12'h008, 32'h0000_00F0, 32'hA5A5_0FFF},
		'{2'h2, 12'h00C, 32'hA500_000F, 32'h00A5_0FF0},
		'{2'h0, 12'h00C, 32'h00A5_0FF0, 32'h00A5_0FF0},
		'{2'h3, 12'h004, 32'hFFFF_FFFF, 32'hFFFF_FFF0},
		'{2'h1, 12'h004, 32'hFFFF_FF00, 32'hFFFF_FFF0},
		'{2'h3, 12'h00C, 32'hFFFF_FFFF, 32'h0000_00F0},
		'{2'h2, 12'h018, 32'h0000_FFFF, 32'h0000_00F0},
		'{2'h2, 12'h01C, 32'h0000_00FF, 32'h0000_00F0},
		'{2'h0, 12'h014, 32'h0000_FF00, 32'h0000_00F0},
		'{2'h3, 12'h018, 32'hFFFF_FFFF, 32'h0000_00F0},
		'{2'h0, 12'h014, 32'hFFFF_FF00, 32'h0000_00F0},
		'{2'h0, 12'h010, 32'h1234_54A0, 32'h0000_00F0},
		'{2'h1, 12'h010, 32'h1234_5400, 32'h0000_00F0},
		'{2'h2, 12'h030, 32'hFFFF_FFFF, 32'h0000_00F0},
		'{2'h0, 12'h030, 32'h0000_0000, 32'h0000_00F0},
		'{2'h3, 12'h028, 32'h0000_0001, 32'h0000_00F0},
		'{2'h0, 12'h028, 32'h0000_0000, 32'h0000_00F0},
		'{2'h2, 12'h028, 32'h0000_0001, 32'h0000_00F0},
		'{2'h1, 12'h028, 32'h0000_0000, 32'h0000_00F0},
		'{2'h0, 12'h028, 32'h0000_0001, 32'h0000_00F0},
		'{2'h3, 12'h204, 32'h0002_0000, 32'h0000_00F0},
		'{2'h0, 12'h204, 32'h0000_0000, 32'h0000_00F0},
		'{2'h2, 12'h224, 32'h0002_0000, 32'h0000_00F0},
		'{2'h0, 12'h224, 32'h0002_0000, 32'h0000_00F0},
		'{2'h0, 12'h020, 32'h0000_0000, 32'h0000_00F0},
		'{2'h2, 12'h024, 32'h0000_0001, 32'h0000_00F0},
		'{2'h1, 12'h024, 32'h0000_0001, 32'h0000_00F0},
		'{2'h2, 12'h104, 32'h0000_0001, 32'h0000_00F0},
		'{2'h0, 12'h108, 32'h0000_0000, 32'h0000_00F0}
	};

	gpr_port gpr_port_i
	(
		.clk_in             (clk_in),
		.rst_in             (rst_in),
		.psel_in            (psel_in),
		.penable_in         (penable_in),
		.pwrite_in          (pwrite_in),
		.paddr_in           (paddr_in),
		.pwdata_in          (pwdata_in),
		.pstrb_in           (pstrb_in),
		.pprot_in           (pprot_in),
		.pready_out         (pready_out),
		.prdata_out         (prdata_out),
		.pslverr_out        (pslverr_out),
		.pin_secure_in      (pin_secure_in),
		.pin_level_in       (pin_level_in),
		.pin_drive_out      (pin_drive_out),
		.pin_drive_en_n_out (pin_drive_en_n_out),
		.detect_nsec_out    (detect_nsec_out),
		.detect_sec_out     (detect_sec_out),
		.irq_out            (irq_out)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	task automatic bail(input string what);
		fail_count++;
		$display("[ERR] %0t timeout %s", $time, what);
		wrap_up();
	endtask : bail

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// Request held until ready is seen high at a rising edge
	task automatic apb(input logic [1:0] op, input logic [11:0] ofs, input logic [31:0] wd,
		output logic [31:0] rdat);
		int n;
		@(posedge clk_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= op[1];
		paddr_in   <= (op[0] ? BASE_NONSECURE : BASE_SECURE) + {20'h0_0000, ofs};
		pwdata_in  <= wd;
		pprot_in   <= {1'b0, op[0], 1'b0};
		@(posedge clk_in);
		penable_in <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_in);
			if (pready_out === 1'b1)
				break;
		end
		if (n == 20)
			bail("apb answer");
		rdat = prdata_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	task automatic wait_irq(input logic want);
		int n;
		for (n = 0; n < 30; n++)
		begin
			@(negedge clk_in);
			if (irq_out === want)
				break;
		end
		if (n == 30)
			bail("irq wait");
	endtask : wait_irq

	////////////////////////////////////////////////////////////////
	initial
	begin
		rst_in        = 1'b1;
		psel_in       = 1'b0;
		penable_in    = 1'b0;
		pwrite_in     = 1'b0;
		paddr_in      = 32'h0000_0000;
		pwdata_in     = 32'h0000_0000;
		pstrb_in      = 4'hF;
		pprot_in      = 3'h0;
		pin_secure_in = 32'h0000_00FF;
		pin_level_in  = 32'h1234_54A0;
		repeat (4) @(posedge clk_in);
		chk(pin_drive_out, 32'h0000_0000, "drive reset");
		chk(pin_drive_en_n_out, 32'hFFFF_FFFF, "dir reset");
		rst_in <= 1'b0;
		$display("test reset done");
		foreach (rows[i])
		begin
			apb(rows[i].op, rows[i].ofs, rows[i].val, rd);
			if (!rows[i].op[1])
				chk(rd, rows[i].val, "row read");
			@(negedge clk_in);
			chk(pin_drive_out, rows[i].drv, "row drive");
		end
		chk(pin_drive_en_n_out, 32'h0000_00FF, "dir pins");
		$display("test table done");
		// Pin 9 senses high, detect select latched, irq enabled
		@(posedge clk_in);
		pin_level_in <= 32'h1234_56A0;
		wait_irq(1'b1);
		apb(2'h0, OFS_SENSE_HIT, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0200, "hit flag");
		apb(2'h2, OFS_SENSE_HIT, 32'h0000_0200, rd);
		apb(2'h0, OFS_SENSE_HIT, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0200, "clear while high");
		@(posedge clk_in);
		pin_level_in <= 32'h1234_54A0;
		repeat (6) @(negedge clk_in);
		chk({31'h0000_0000, detect_nsec_out}, 32'h0000_0001, "detect held");
		apb(2'h2, OFS_SENSE_HIT, 32'h0000_0200, rd);
		apb(2'h0, OFS_SENSE_HIT, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000, "hit cleared");
		repeat (3) @(negedge clk_in);
		chk({31'h0000_0000, detect_nsec_out}, 32'h0000_0000, "detect gone");
		apb(2'h2, OFS_IRQ_CLEAR, 32'h0000_0001, rd);
		wait_irq(1'b0);
		apb(2'h0, OFS_IRQ_STATUS, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000, "irq cleared");
		// Masked: status still sets, line stays low
		apb(2'h2, OFS_IRQ_ENABLE, 32'h0000_0000, rd);
		@(posedge clk_in);
		pin_level_in <= 32'h1234_56A0;
		repeat (6) @(negedge clk_in);
		chk({31'h0000_0000, irq_out}, 32'h0000_0000, "irq masked");
		apb(2'h0, OFS_IRQ_STATUS, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0001, "masked status");
		// Secure pin 1 senses high, its select is latched
		apb(2'h2, 12'h204, 32'h0002_0000, rd);
		@(posedge clk_in);
		pin_level_in <= 32'h1234_56A2;
		repeat (6) @(negedge clk_in);
		chk({31'h0000_0000, detect_sec_out}, 32'h0000_0001, "secure detect");
		apb(2'h1, OFS_SENSE_HIT, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0200, "ns hit masked");
		apb(2'h0, OFS_SENSE_HIT, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0202, "secure hit");
		$display("test sense done");
		// Reset again mid-run with the bus idle
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (2) @(negedge clk_in);
		chk(pin_drive_out, RST_DRIVE_LEVEL, "drive mid reset");
		chk({31'h0000_0000, irq_out}, 32'h0000_0000, "irq mid reset");
		@(posedge clk_in);
		rst_in <= 1'b0;
		apb(2'h0, OFS_DRIVE_LEVEL, 32'h0000_0000, rd);
		chk(rd, RST_DRIVE_LEVEL, "drive after reset");
		$display("test reset again done");
		wrap_up();
	end
endmodule : testbench
